//--- logic/cso_pkg.sv
package cso_pkg;

  // Register byte offsets
  localparam logic [7:0] CSO_OFF_CTRL0  = 8'h00;
  localparam logic [7:0] CSO_OFF_CTRL1  = 8'h04;
  localparam logic [7:0] CSO_OFF_T0CFG  = 8'h08;
  localparam logic [7:0] CSO_OFF_T1CTRL = 8'h0C;
  localparam logic [7:0] CSO_OFF_T0CNT  = 8'h10;
  localparam logic [7:0] CSO_OFF_T1CNT  = 8'h14;
  localparam logic [7:0] CSO_OFF_STAT   = 8'h18;

  // Control 0 fields
  localparam int CSO_C0_EN   = 7;
  localparam int CSO_C0_RM   = 6;
  localparam int CSO_C0_RNG  = 2;
  localparam int CSO_C0_DIR  = 1;
  localparam int CSO_C0_T0XS = 0;

  // Control 1 field
  localparam int CSO_C1_CH   = 0;

  // Timer0 config field
  localparam int CSO_T0_CS   = 0;

  // Timer1 control fields
  localparam int CSO_T1_CS   = 6;
  localparam int CSO_T1_GE   = 1;
  localparam int CSO_T1_ON   = 0;

  // Status fields
  localparam int CSO_ST_T0OV  = 0;
  localparam int CSO_ST_SLEEP = 1;

  // Reset values
  localparam logic [7:0] CSO_RST_CTRL0  = 8'h00;
  localparam logic [3:0] CSO_RST_CTRL1  = 4'h0;
  localparam logic       CSO_RST_T0CS   = 1'b1;
  localparam logic [7:0] CSO_RST_T1CTRL = 8'h00;

  // Encodings
  localparam logic [1:0] CSO_RNG_OFF   = 2'b00;
  localparam logic [1:0] CSO_T1CS_OSC  = 2'b11;

  // Instruction clock divides system clock by four
  localparam int CSO_FOSC_DIV = 4;

  typedef enum logic [1:0] {
    CSO_MODE_OFF,
    CSO_MODE_NOISE,
    CSO_MODE_DRIVE
  } cso_mode_t;

endpackage : cso_pkg

//--- logic/cso_sync_edge.sv
`timescale 1ns/1ps
module cso_sync_edge (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Asynchronous level in
  input  wire logic async_in,
  // Synchronised level and rising edge pulse
  output logic      level_o,
  output logic      rise_o
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  // Three flops; the second and third are read by logic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_o = sync_q;
  assign rise_o  = sync_q & ~prev_q;

endmodule : cso_sync_edge

//--- logic/cso_top.sv
`timescale 1ns/1ps
module cso_top
  import cso_pkg::*;
#(
  parameter int T0_WIDTH = 8,
  parameter int T1_WIDTH = 16
) (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Oscillator and system inputs
  input  wire logic        osc_comp_in,
  input  wire logic        sleep_in,
  input  wire logic        timer1_gate_in,
  input  wire logic        t0_ext_pin_in,
  // Oscillator controls
  output logic             osc_enable_q,
  output logic             ref_variable_q,
  output logic [1:0]       current_level_q,
  output logic             current_drive_q,
  output logic             noise_mode_q,
  output logic [3:0]       channel_sel_q,
  output logic             channel_valid_q,
  // Timer events
  output logic             timer0_ovf_pulse_q,
  output logic             timer1_ovf_pulse_q
);

  // Software-visible state and internal signals
  logic                sense_module_enable_q;
  logic                reference_range_select_q;
  logic [1:0]          current_range_field_q;
  logic                timer0_external_source_select_q;
  logic [3:0]          channel_field_q;
  logic                timer0_clock_source_bit_q;
  logic [1:0]          timer1_clock_source_field_q;
  logic                timer1_gate_enable_q;
  logic                timer1_on_bit_q;
  logic [T0_WIDTH-1:0] t0_count_q;
  logic [T1_WIDTH-1:0] t1_count_q;
  logic                t0_ovf_flag_q;
  logic [1:0]          div_q;
  logic                fosc4_en;
  logic                osc_level;
  logic                osc_rise;
  logic                pin_rise;
  logic                wr_en;
  logic                setup;
  logic                t0_tick;
  logic                t1_tick;
  logic                t0_ovf;
  logic                t1_ovf;
  cso_mode_t           mode;

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == CSO_OFF_CTRL0)  || (a == CSO_OFF_CTRL1) ||
                  (a == CSO_OFF_T0CFG)  || (a == CSO_OFF_T1CTRL) ||
                  (a == CSO_OFF_T0CNT)  || (a == CSO_OFF_T1CNT) ||
                  (a == CSO_OFF_STAT);
  endfunction : addr_mapped

  // Oscillator and pin edges brought into pclk before counting
  cso_sync_edge u_osc_sync (
    .clk      (pclk),
    .rst_n    (presetn),
    .async_in (osc_comp_in),
    .level_o  (osc_level),
    .rise_o   (osc_rise)
  );

  cso_sync_edge u_pin_sync (
    .clk      (pclk),
    .rst_n    (presetn),
    .async_in (t0_ext_pin_in),
    .level_o  (),
    .rise_o   (pin_rise)
  );

  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite;

  // Power mode decode
  always_comb begin
    if (!sense_module_enable_q) begin
      mode = CSO_MODE_OFF;
    end else if (current_range_field_q == CSO_RNG_OFF) begin
      mode = reference_range_select_q ? CSO_MODE_NOISE : CSO_MODE_OFF;
    end else begin
      mode = CSO_MODE_DRIVE;
    end
  end

  // Instruction clock enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 2'b00;
    end else begin
      div_q <= (div_q == 2'(CSO_FOSC_DIV - 1)) ? 2'b00 : div_q + 2'b01;
    end
  end
  assign fosc4_en = (div_q == 2'(CSO_FOSC_DIV - 1));

  // Timer0 source: oscillator, pin, or instruction clock; stopped in sleep
  always_comb begin
    if (sleep_in) begin
      t0_tick = 1'b0;
    end else if (!timer0_clock_source_bit_q && timer0_external_source_select_q) begin
      t0_tick = osc_rise;
    end else if (timer0_clock_source_bit_q) begin
      t0_tick = pin_rise;
    end else begin
      t0_tick = fosc4_en;
    end
  end

  // Timer1 enable and source; oscillator path keeps counting in sleep
  always_comb begin
    t1_tick = 1'b0;
    if (timer1_on_bit_q && (!timer1_gate_enable_q || timer1_gate_in)) begin
      if (timer1_clock_source_field_q == CSO_T1CS_OSC) begin
        t1_tick = osc_rise;
      end else begin
        t1_tick = fosc4_en & ~sleep_in;
      end
    end
  end

  assign t0_ovf = t0_tick & (&t0_count_q);
  assign t1_ovf = t1_tick & (&t1_count_q);

  // APB handshake: no wait state, answer registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~addr_mapped(paddr);
    end
  end

  // Read data latched during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= 32'h0000_0000;
      case (paddr)
        CSO_OFF_CTRL0: begin
          prdata[CSO_C0_EN]             <= sense_module_enable_q;
          prdata[CSO_C0_RM]             <= reference_range_select_q;
          prdata[CSO_C0_RNG +: 2]       <= current_range_field_q;
          prdata[CSO_C0_DIR]            <= sense_module_enable_q &
                                           (mode != CSO_MODE_OFF) & osc_level;
          prdata[CSO_C0_T0XS]           <= timer0_external_source_select_q;
        end
        CSO_OFF_CTRL1:  prdata[CSO_C1_CH +: 4] <= channel_field_q;
        CSO_OFF_T0CFG:  prdata[CSO_T0_CS]      <= timer0_clock_source_bit_q;
        CSO_OFF_T1CTRL: begin
          prdata[CSO_T1_CS +: 2]        <= timer1_clock_source_field_q;
          prdata[CSO_T1_GE]             <= timer1_gate_enable_q;
          prdata[CSO_T1_ON]             <= timer1_on_bit_q;
        end
        CSO_OFF_T0CNT:  prdata[T0_WIDTH-1:0]   <= t0_count_q;
        CSO_OFF_T1CNT:  prdata[T1_WIDTH-1:0]   <= t1_count_q;
        CSO_OFF_STAT: begin
          prdata[CSO_ST_T0OV]           <= t0_ovf_flag_q;
          prdata[CSO_ST_SLEEP]          <= sleep_in;
        end
        default:        prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Sense control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_module_enable_q           <= CSO_RST_CTRL0[CSO_C0_EN];
      reference_range_select_q        <= CSO_RST_CTRL0[CSO_C0_RM];
      current_range_field_q           <= CSO_RST_CTRL0[CSO_C0_RNG +: 2];
      timer0_external_source_select_q <= CSO_RST_CTRL0[CSO_C0_T0XS];
      channel_field_q                 <= CSO_RST_CTRL1;
    end else if (wr_en) begin
      if (paddr == CSO_OFF_CTRL0) begin
        sense_module_enable_q           <= pwdata[CSO_C0_EN];
        reference_range_select_q        <= pwdata[CSO_C0_RM];
        current_range_field_q           <= pwdata[CSO_C0_RNG +: 2];
        timer0_external_source_select_q <= pwdata[CSO_C0_T0XS];
      end
      if (paddr == CSO_OFF_CTRL1) begin
        channel_field_q <= pwdata[CSO_C1_CH +: 4];
      end
    end
  end

  // Timer configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer0_clock_source_bit_q   <= CSO_RST_T0CS;
      timer1_clock_source_field_q <= CSO_RST_T1CTRL[CSO_T1_CS +: 2];
      timer1_gate_enable_q        <= CSO_RST_T1CTRL[CSO_T1_GE];
      timer1_on_bit_q             <= CSO_RST_T1CTRL[CSO_T1_ON];
    end else if (wr_en) begin
      if (paddr == CSO_OFF_T0CFG) begin
        timer0_clock_source_bit_q <= pwdata[CSO_T0_CS];
      end
      if (paddr == CSO_OFF_T1CTRL) begin
        timer1_clock_source_field_q <= pwdata[CSO_T1_CS +: 2];
        timer1_gate_enable_q        <= pwdata[CSO_T1_GE];
        timer1_on_bit_q             <= pwdata[CSO_T1_ON];
      end
    end
  end

  // Timer0 counter; a write loads it, a tick increments it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t0_count_q <= '0;
    end else if (wr_en && paddr == CSO_OFF_T0CNT) begin
      t0_count_q <= pwdata[T0_WIDTH-1:0];
    end else if (t0_tick) begin
      t0_count_q <= t0_count_q + 1'b1;
    end
  end

  // Timer1 counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t1_count_q <= '0;
    end else if (wr_en && paddr == CSO_OFF_T1CNT) begin
      t1_count_q <= pwdata[T1_WIDTH-1:0];
    end else if (t1_tick) begin
      t1_count_q <= t1_count_q + 1'b1;
    end
  end

  // Timer0 overflow flag, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t0_ovf_flag_q <= 1'b0;
    end else if (t0_ovf) begin
      t0_ovf_flag_q <= 1'b1;
    end else if (wr_en && paddr == CSO_OFF_STAT && pwdata[CSO_ST_T0OV]) begin
      t0_ovf_flag_q <= 1'b0;
    end
  end

  // Overflow pulses for time base logic outside
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer0_ovf_pulse_q <= 1'b0;
      timer1_ovf_pulse_q <= 1'b0;
    end else begin
      timer0_ovf_pulse_q <= t0_ovf;
      timer1_ovf_pulse_q <= t1_ovf;
    end
  end

  // Oscillator analog controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_enable_q    <= 1'b0;
      ref_variable_q  <= 1'b0;
      current_level_q <= CSO_RNG_OFF;
      current_drive_q <= 1'b0;
      noise_mode_q    <= 1'b0;
      channel_sel_q   <= 4'h0;
      channel_valid_q <= 1'b0;
    end else begin
      osc_enable_q    <= (mode != CSO_MODE_OFF);
      ref_variable_q  <= reference_range_select_q;
      current_level_q <= current_range_field_q;
      current_drive_q <= (mode == CSO_MODE_DRIVE);
      noise_mode_q    <= (mode == CSO_MODE_NOISE);
      channel_sel_q   <= sense_module_enable_q ? channel_field_q : 4'h0;
      channel_valid_q <= sense_module_enable_q;
    end
  end

endmodule : cso_top

//--- tb/cso_top_sva.sv
`timescale 1ns/1ps
module cso_top_sva (
  // Bus
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  // Mode and timer
  input wire logic       sleep_in,
  input wire logic       osc_enable_q,
  input wire logic       ref_variable_q,
  input wire logic [1:0] current_level_q,
  input wire logic       current_drive_q,
  input wire logic       noise_mode_q,
  input wire logic [3:0] channel_sel_q,
  input wire logic       channel_valid_q,
  input wire logic       timer0_ovf_pulse_q
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_wait: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_noise_mode: assert property (noise_mode_q |-> ref_variable_q &&
    current_level_q == 2'b00 && osc_enable_q && !current_drive_q)
    else $error("noise mode with wrong settings");
  chk_drive_level: assert property (current_drive_q |-> current_level_q != 2'b00 &&
    osc_enable_q) else $error("current drive with field off");
  chk_osc_gate: assert property (osc_enable_q |-> channel_valid_q &&
    (current_drive_q || noise_mode_q)) else $error("oscillator on without mode");
  chk_chan_off: assert property (!channel_valid_q |-> channel_sel_q == 4'h0 &&
    !osc_enable_q) else $error("channel selected while disabled");
  chk_ovf_pulse: assert property (timer0_ovf_pulse_q |=> !timer0_ovf_pulse_q)
    else $error("overflow pulse too wide");
  chk_t0_sleep: assert property (sleep_in [*3] |-> !timer0_ovf_pulse_q)
    else $error("timer0 overflow in sleep");
endmodule : cso_top_sva

//--- tb/cso_osc_model.sv
`timescale 1ns/1ps
module cso_osc_model (
  // Clock and control
  input wire logic       pclk,
  input wire logic       run,
  input wire logic       osc_on,
  input wire logic [7:0] half,
  // Oscillator
  output logic           osc_out,
  output int             rises
);
  int  cnt = 0;
  wire act = run & osc_on;
  initial osc_out = 1'b0;
  initial rises = 0;
  // A started high phase always finishes, so each level lasts half cycles
  always @(posedge pclk) begin
    if (act || osc_out) begin
      if (cnt + 1 >= int'(half)) begin
        cnt <= 0;
        osc_out <= !osc_out && act;
        if (!osc_out && act) rises <= rises + 1;
      end else cnt <= cnt + 1;
    end else cnt <= 0;
  end
endmodule : cso_osc_model

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import cso_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, half = 8'd2;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, osc_comp_in, run = 1'b0;
  logic sleep_in = 1'b0, timer1_gate_in = 1'b0, t0_ext_pin_in = 1'b0;
  logic osc_enable_q, ref_variable_q, current_drive_q, noise_mode_q, channel_valid_q;
  logic [1:0] current_level_q;
  logic [3:0] channel_sel_q, ch;
  logic timer0_ovf_pulse_q, timer1_ovf_pulse_q;
  logic [7:0] t1c [4] = '{8'hC1, 8'hC3, 8'hC3, 8'hC0};
  int mismatches = 0, checks_done = 0, ovf_seen = 0, t1_seen = 0, rises, got, r0, t0v;

  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    if (timer0_ovf_pulse_q === 1'b1) ovf_seen++;
    if (timer1_ovf_pulse_q === 1'b1) t1_seen++;
  end

  cso_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .osc_comp_in(osc_comp_in), .sleep_in(sleep_in),
    .timer1_gate_in(timer1_gate_in), .t0_ext_pin_in(t0_ext_pin_in),
    .osc_enable_q(osc_enable_q), .ref_variable_q(ref_variable_q),
    .current_level_q(current_level_q), .current_drive_q(current_drive_q),
    .noise_mode_q(noise_mode_q), .channel_sel_q(channel_sel_q),
    .channel_valid_q(channel_valid_q), .timer0_ovf_pulse_q(timer0_ovf_pulse_q),
    .timer1_ovf_pulse_q(timer1_ovf_pulse_q));
  cso_osc_model osc (.pclk(pclk), .run(run), .osc_on(osc_enable_q), .half(half),
    .osc_out(osc_comp_in), .rises(rises));

  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin mismatches++; give_verdict(); end
    else begin rd = prdata; er = pslverr; psel <= 1'b0; penable <= 1'b0; end
  endtask : apb

  // Fixed window timed by the bench, not by the counted timer
  task automatic count(input int cyc, output int d);
    int s;
    s = rises;
    half <= 8'($urandom_range(4, 2));
    run <= 1'b1;
    repeat (cyc) @(posedge pclk);
    run <= 1'b0;
    repeat (12) @(posedge pclk);
    d = rises - s;
  endtask : count

  function automatic logic [31:0] exp_mode(logic en, logic rm, logic [1:0] rg, logic [3:0] c);
    return 32'({en && (rm || rg != 2'b00), rm, rg, en && rg != 2'b00,
                en && rm && rg == 2'b00, en, en ? c : 4'h0});
  endfunction : exp_mode

  initial begin
    r0 = $urandom(7);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, CSO_OFF_CTRL0, 0); cmp(rd, 32'h0);
    apb(0, CSO_OFF_T0CFG, 0); cmp(rd, 32'h1);
    apb(1, 8'h1C, 32'hFFFF_FFFF); cmp(32'(er), 32'h1);
    apb(0, 8'h1C, 0); cmp({rd[30:0], er}, 32'h1);
    for (int i = 0; i < 16; i++) begin
      ch = 4'($urandom);
      apb(1, CSO_OFF_CTRL1, 32'(ch));
      apb(1, CSO_OFF_CTRL0, {24'h0, i[3], i[2], 2'b00, i[1:0], 2'b00});
      repeat (2) @(posedge pclk);
      cmp(32'({osc_enable_q, ref_variable_q, current_level_q, current_drive_q, noise_mode_q,
        channel_valid_q, channel_sel_q}), exp_mode(i[3], i[2], i[1:0], ch));
      apb(0, CSO_OFF_CTRL0, 0); cmp(rd, {24'h0, i[3], i[2], 2'b00, i[1:0], 2'b00});
    end
    for (int k = 0; k < 4; k++) begin
      apb(1, CSO_OFF_CTRL0, k < 2 ? 32'h0000_00C0 : 32'h0000_008C);
      apb(1, CSO_OFF_T1CTRL, 32'(t1c[k]));
      apb(1, CSO_OFF_T1CNT, 0);
      timer1_gate_in <= k > 1;
      sleep_in <= k == 2;
      count(150, got);
      apb(0, CSO_OFF_T1CNT, 0); cmp(rd, (k % 2 == 1) ? 32'h0 : 32'(got));
    end
    sleep_in <= 1'b0;
    apb(1, CSO_OFF_CTRL0, 32'h0000_0085);
    apb(1, CSO_OFF_T0CFG, 0);
    apb(1, CSO_OFF_T0CNT, 32'h0000_00FE);
    ovf_seen = 0;
    count(100, got);
    apb(0, CSO_OFF_T0CNT, 0); cmp(rd, 32'(8'(254 + got)));
    t0v = 254 + got;
    cmp(32'(ovf_seen), 32'h1);
    apb(0, CSO_OFF_STAT, 0); cmp(rd, 32'h1);
    apb(1, CSO_OFF_STAT, 32'h1);
    sleep_in <= 1'b1;
    count(100, got);
    apb(0, CSO_OFF_STAT, 0); cmp(rd, 32'h2);
    apb(0, CSO_OFF_T0CNT, 0); cmp(rd, 32'(8'(t0v)));
    sleep_in <= 1'b0;
    // Unloaded then loaded pad over the same window
    apb(1, CSO_OFF_T1CTRL, 32'h0000_00C1);
    for (int j = 0; j < 2; j++) begin
      apb(1, CSO_OFF_T1CNT, 0);
      half <= 8'(2 + 2 * j);
      run <= 1'b1;
      repeat (150) @(posedge pclk);
      run <= 1'b0;
      repeat (12) @(posedge pclk);
      apb(0, CSO_OFF_T1CNT, 0);
      if (j == 0) r0 = int'(rd);
      else got = int'(rd);
    end
    cmp(32'(got < (r0 + got) / 2 && (r0 + got) / 2 < r0), 32'h1);
    // Timer1 wrap from the oscillator
    apb(1, CSO_OFF_T1CNT, 32'h0000_FFFE);
    t1_seen = 0;
    count(100, got);
    apb(0, CSO_OFF_T1CNT, 0); cmp(rd, 32'(16'(65534 + got)));
    cmp(32'(t1_seen), 32'h1);
    // Timer0 from the pin
    apb(1, CSO_OFF_T0CFG, 32'h0000_0001);
    apb(1, CSO_OFF_T0CNT, 0);
    repeat (10) begin
      t0_ext_pin_in <= ~t0_ext_pin_in;
      repeat (3) @(posedge pclk);
    end
    apb(0, CSO_OFF_T0CNT, 0); cmp(rd, 32'h5);
    // Timer1 from the instruction clock, stopped in sleep
    for (int j = 0; j < 2; j++) begin
      sleep_in <= (j == 1);
      apb(1, CSO_OFF_T1CTRL, 32'h0000_0001);
      apb(1, CSO_OFF_T1CNT, 0);
      repeat (40) @(posedge pclk);
      apb(0, CSO_OFF_T1CNT, 0);
      cmp(32'(j == 0 ? (rd == 32'd10 || rd == 32'd11) : rd == 32'd0), 32'h1);
    end
    sleep_in <= 1'b0;
    half <= 8'd60;
    run <= 1'b1;
    repeat (70) @(posedge pclk);
    apb(0, CSO_OFF_CTRL0, 0); cmp(32'(rd[1]), 32'h1);
    run <= 1'b0;
    repeat (70) @(posedge pclk);
    apb(0, CSO_OFF_CTRL0, 0); cmp(32'(rd[1]), 32'h0);
    give_verdict();
  end

  initial begin
    repeat (60000) @(posedge pclk);
    mismatches++;
    give_verdict();
  end
endmodule : testbench

bind cso_top cso_top_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .sleep_in(sleep_in),
  .osc_enable_q(osc_enable_q), .ref_variable_q(ref_variable_q),
  .current_level_q(current_level_q), .current_drive_q(current_drive_q),
  .noise_mode_q(noise_mode_q), .channel_sel_q(channel_sel_q),
  .channel_valid_q(channel_valid_q), .timer0_ovf_pulse_q(timer0_ovf_pulse_q));
